// ---- sarseq_defines.svh ----
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH

// Register offsets
`define SARSEQ_OFF_CTRL0      8'hD6
`define SARSEQ_OFF_CTRL1      8'hD7
`define SARSEQ_OFF_CTRL2      8'hD8
`define SARSEQ_OFF_RES_LO     8'hD9
`define SARSEQ_OFF_RES_HI     8'hDA
`define SARSEQ_OFF_IRQ_STAT   8'hDB
`define SARSEQ_OFF_IRQ_MASK   8'hDC

// Control 0 fields
`define SARSEQ_C0_CH_LSB      0
`define SARSEQ_C0_MODE        3
`define SARSEQ_C0_GRP_EN      4
`define SARSEQ_C0_START       6
`define SARSEQ_C0_CKS_LO      7
// Control 1 fields
`define SARSEQ_C1_RES10       3
`define SARSEQ_C1_CKS_HI      4
`define SARSEQ_C1_REF_CONN    5
// Control 2 fields
`define SARSEQ_C2_SH_EN       0

// Writable bit masks, reserved bits read zero
`define SARSEQ_C0_WMASK       8'hDF
`define SARSEQ_C1_WMASK       8'h38
`define SARSEQ_C2_WMASK       8'h01

// Reset values
`define SARSEQ_RST_CTRL       8'h00

// Conversion lengths in converter clock cycles
`define SARSEQ_CYC_8_NOSH     7'd49
`define SARSEQ_CYC_10_NOSH    7'd59
`define SARSEQ_CYC_8_SH       7'd28
`define SARSEQ_CYC_10_SH      7'd33

// Full-scale codes
`define SARSEQ_FULL_10        10'h3FF
`define SARSEQ_FULL_8         10'h0FF

`endif

// ---- sarseq_pkg.sv ----
package sarseq_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        SARSEQ_IDLE,
        SARSEQ_CONV,
        SARSEQ_DONE
    } sarseq_state_t;

    // Converter clock sources
    typedef enum logic [1:0] {
        SARSEQ_CK_DIV4,
        SARSEQ_CK_DIV2,
        SARSEQ_CK_DIV1,
        SARSEQ_CK_OSC
    } sarseq_clk_t;

endpackage : sarseq_pkg

// ---- sarseq_top.sv ----
// Operation
// R1: Channel patterns 100..111 pick inputs 0..3
// R2: Channel select valid only with group enable
// R3: Mode bit: 0 one-shot, 1 repeat
// R4: Start write 1 begins, 0 stops
// R5: One-shot clears start flag, raises interrupt
// R6: Repeat converts until stopped, no interrupt
// R7: Software uses 8-bit only in repeat
// R8: Resolution bit: 0 8-bit, 1 10-bit
// R9: Clock select: div4, div2, div1, oscillator
// R10: Over-reference input gives full-scale code
// R11: Conversion lengths 49/59, with hold 28/33
// R12: Sample-hold enable shortens conversion sequence
// R13: Control 0 write mid-conversion spoils result
// R14: Finished conversion stores result register
// R15: Reference connect bit drives ladder switch
// R16: Software reselects channel after mode change
// R17: Software changes settings only while stopped
// R18: Start flag reads 1 while sequence active
`timescale 1ns/1ns
`include "sarseq_defines.svh"

module sarseq_top #(
    parameter int DATA_W = 10                 // Converter result width
) (
    input  wire logic              ref_clk,         // System clock
    input  wire logic              rst_n,           // Async reset, low
    input  wire logic [7:0]        addr,            // Register address
    input  wire logic [7:0]        wdata,           // Write data
    input  wire logic              wr_stb,          // Write strobe
    input  wire logic              rd_stb,          // Read strobe
    output logic      [7:0]        rdata,           // Read data
    input  wire logic              osc_fast_tick,   // Fast oscillator tick
    input  wire logic [DATA_W-1:0] sar_code,        // Raw comparator code
    input  wire logic              sar_over_ref,    // Input above reference
    output logic                   analog_input_0,  // Mux select input 0
    output logic                   analog_input_1,  // Mux select input 1
    output logic                   analog_input_2,  // Mux select input 2
    output logic                   analog_input_3,  // Mux select input 3
    output logic                   ladder_connect,  // Reference to ladder
    output logic                   sample_hold_on,  // Hold circuit active
    output logic                   conv_busy,       // Conversion running
    output logic                   irq              // Interrupt, level
);

    // Register storage
    logic [7:0]        converter_control_0;   // Channel, mode, start, clock
    logic [7:0]        converter_control_1;   // Resolution, clock, ref
    logic [7:0]        converter_control_2;   // Sample-hold enable
    logic [DATA_W-1:0] result;                // Last conversion value
    logic              result_bad;            // Result spoiled flag
    logic [1:0]        irq_status;            // Sticky events
    logic [1:0]        irq_mask;              // Event enables

    // Sequencer state
    sarseq_pkg::sarseq_state_t state;         // Current state
    logic [6:0]        cyc_cnt;               // Converter cycles done
    logic [1:0]        div_cnt;               // System clock divider
    logic              ck_en;                 // Converter clock enable
    logic [6:0]        cyc_len;               // Cycles per conversion
    logic [DATA_W-1:0] next_result;           // Value to store
    logic              conv_end;              // Last converter cycle
    logic              wr_c0;                 // Control 0 write
    logic              start_wr1;             // Start written as 1
    logic              start_wr0;             // Start written as 0

    // Field views
    wire       mode_repeat = converter_control_0[`SARSEQ_C0_MODE];
    wire       grp_en      = converter_control_0[`SARSEQ_C0_GRP_EN];
    wire       res10       = converter_control_1[`SARSEQ_C1_RES10];
    wire       sh_en       = converter_control_2[`SARSEQ_C2_SH_EN];
    wire [2:0] ch_sel      = converter_control_0[`SARSEQ_C0_CH_LSB +: 3];
    sarseq_pkg::sarseq_clk_t clk_src;

    // Decode of bus writes
    assign wr_c0     = wr_stb && (addr == `SARSEQ_OFF_CTRL0);
    assign start_wr1 = wr_c0 && wdata[`SARSEQ_C0_START];
    assign start_wr0 = wr_c0 && !wdata[`SARSEQ_C0_START];

    // Clock source from the two select bits
    assign clk_src = sarseq_pkg::sarseq_clk_t'({
        converter_control_1[`SARSEQ_C1_CKS_HI],
        converter_control_0[`SARSEQ_C0_CKS_LO]});

    // Divider for the system clock based rates
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    // Converter clock enable pulse
    always_comb begin
        case (clk_src)                                          // R9
            sarseq_pkg::SARSEQ_CK_DIV4: ck_en = (div_cnt == 2'h3);
            sarseq_pkg::SARSEQ_CK_DIV2: ck_en = div_cnt[0];
            sarseq_pkg::SARSEQ_CK_DIV1: ck_en = 1'b1;
            sarseq_pkg::SARSEQ_CK_OSC:  ck_en = osc_fast_tick;
            default:                    ck_en = 1'b0;
        endcase
    end

    // Conversion length per resolution and hold option
    always_comb begin
        if (sh_en) begin                                        // R12
            cyc_len = res10 ? `SARSEQ_CYC_10_SH                 // R11
                            : `SARSEQ_CYC_8_SH;
        end else begin
            cyc_len = res10 ? `SARSEQ_CYC_10_NOSH
                            : `SARSEQ_CYC_8_NOSH;
        end
    end

    assign conv_end = (state == sarseq_pkg::SARSEQ_CONV) && ck_en
                   && (cyc_cnt == cyc_len - 7'd1);

    // Result value, clamped and cut to resolution
    always_comb begin
        if (sar_over_ref) begin                                 // R10
            next_result = res10 ? `SARSEQ_FULL_10 : `SARSEQ_FULL_8;
        end else if (res10) begin                               // R8
            next_result = sar_code;
        end else begin
            next_result = {2'h0, sar_code[DATA_W-1:2]};
        end
    end

    // Control register 0, start flag owned by sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_control_0 <= `SARSEQ_RST_CTRL;
        end else begin
            if (wr_c0) begin                                    // R4
                converter_control_0 <= wdata & `SARSEQ_C0_WMASK;
            end else if (conv_end && !mode_repeat) begin
                converter_control_0[`SARSEQ_C0_START] <= 1'b0;  // R5
            end
        end
    end

    // Control registers 1 and 2
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_control_1 <= `SARSEQ_RST_CTRL;
            converter_control_2 <= `SARSEQ_RST_CTRL;
        end else begin
            if (wr_stb && addr == `SARSEQ_OFF_CTRL1) begin
                converter_control_1 <= wdata & `SARSEQ_C1_WMASK;
            end
            if (wr_stb && addr == `SARSEQ_OFF_CTRL2) begin
                converter_control_2 <= wdata & `SARSEQ_C2_WMASK;
            end
        end
    end

    // Sequencer and converter cycle counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= sarseq_pkg::SARSEQ_IDLE;
            cyc_cnt <= 7'h00;
        end else begin
            case (state)
                sarseq_pkg::SARSEQ_IDLE: begin
                    cyc_cnt <= 7'h00;
                    if (start_wr1) begin                        // R4
                        state <= sarseq_pkg::SARSEQ_CONV;
                    end
                end
                sarseq_pkg::SARSEQ_CONV: begin
                    if (start_wr0) begin                        // R4
                        state   <= sarseq_pkg::SARSEQ_IDLE;
                        cyc_cnt <= 7'h00;
                    end else if (conv_end) begin
                        cyc_cnt <= 7'h00;
                        // Repeat keeps going, one-shot ends
                        state <= mode_repeat                    // R6
                               ? sarseq_pkg::SARSEQ_CONV
                               : sarseq_pkg::SARSEQ_DONE;       // R3
                    end else if (ck_en) begin
                        cyc_cnt <= cyc_cnt + 7'd1;
                    end
                end
                sarseq_pkg::SARSEQ_DONE: begin
                    // One cycle in done, a start write here goes straight to conversion
                    state <= start_wr1 ? sarseq_pkg::SARSEQ_CONV
                                       : sarseq_pkg::SARSEQ_IDLE;
                end
                default: begin
                    state <= sarseq_pkg::SARSEQ_IDLE;
                end
            endcase
        end
    end

    // Result register and spoiled marker
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result     <= '0;
            result_bad <= 1'b0;
        end else begin
            if (conv_end) begin                                 // R14
                result     <= next_result;
                result_bad <= 1'b0;
            end else if (wr_c0 && state == sarseq_pkg::SARSEQ_CONV) begin
                result_bad <= 1'b1;                             // R13
            end
        end
    end

    // Sticky events: bit0 one-shot done, bit1 spoiled result
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
        end else begin
            if (wr_stb && addr == `SARSEQ_OFF_IRQ_MASK) begin
                irq_mask <= wdata[1:0];
            end
            // Set wins over write-one-clear
            irq_status[0] <= (conv_end && !mode_repeat)         // R5 R6
                || (irq_status[0] && !(wr_stb
                    && addr == `SARSEQ_OFF_IRQ_STAT && wdata[0]));
            irq_status[1] <= (wr_c0 && state == sarseq_pkg::SARSEQ_CONV)
                || (irq_status[1] && !(wr_stb
                    && addr == `SARSEQ_OFF_IRQ_STAT && wdata[1]));
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_input_0 <= 1'b0;
            analog_input_1 <= 1'b0;
            analog_input_2 <= 1'b0;
            analog_input_3 <= 1'b0;
            ladder_connect <= 1'b0;
            sample_hold_on <= 1'b0;
            conv_busy      <= 1'b0;
            irq            <= 1'b0;
        end else begin
            // Mux select only with group enabled and legal code
            analog_input_0 <= grp_en && ch_sel == 3'h4;         // R1 R2
            analog_input_1 <= grp_en && ch_sel == 3'h5;
            analog_input_2 <= grp_en && ch_sel == 3'h6;
            analog_input_3 <= grp_en && ch_sel == 3'h7;
            ladder_connect <=
                converter_control_1[`SARSEQ_C1_REF_CONN];       // R15
            sample_hold_on <= sh_en
                && (state == sarseq_pkg::SARSEQ_CONV);          // R12
            conv_busy      <= (state == sarseq_pkg::SARSEQ_CONV);
            irq            <= |(irq_status & irq_mask);
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            case (addr)
                `SARSEQ_OFF_CTRL0:    rdata <= converter_control_0; // R18
                `SARSEQ_OFF_CTRL1:    rdata <= converter_control_1;
                `SARSEQ_OFF_CTRL2:    rdata <= converter_control_2;
                `SARSEQ_OFF_RES_LO:   rdata <= result[7:0];
                `SARSEQ_OFF_RES_HI:   rdata <= {result_bad, 5'h00,
                                                result[9:8]};
                `SARSEQ_OFF_IRQ_STAT: rdata <= {6'h00, irq_status};
                `SARSEQ_OFF_IRQ_MASK: rdata <= {6'h00, irq_mask};
                default:              rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule : sarseq_top

// ---- sarseq_sva.sv ----
`timescale 1ns/1ns
`include "sarseq_defines.svh"
module sarseq_sva #(
    parameter int DATA_W = 10                 // Result width
) (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic [7:0]        addr,
    input wire logic [7:0]        wdata,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [7:0]        rdata,
    input wire logic              osc_fast_tick,
    input wire logic [DATA_W-1:0] sar_code,
    input wire logic              sar_over_ref,
    input wire logic              analog_input_0,
    input wire logic              analog_input_1,
    input wire logic              analog_input_2,
    input wire logic              analog_input_3,
    input wire logic              ladder_connect,
    input wire logic              sample_hold_on,
    input wire logic              conv_busy,
    input wire logic              irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Control 0 write while idle, start bit set
    sequence s_go;
        wr_stb && addr == `SARSEQ_OFF_CTRL0 && wdata[6] && !conv_busy;
    endsequence
    // Control 0 write during conversion, start bit clear
    sequence s_halt;
        wr_stb && addr == `SARSEQ_OFF_CTRL0 && !wdata[6] && conv_busy;
    endsequence
    // Mux pattern write with and without group enable
    sequence s_ch1_on;
        wr_stb && addr == `SARSEQ_OFF_CTRL0 && wdata[4:0] == 5'h15;
    endsequence
    sequence s_grp_off;
        wr_stb && addr == `SARSEQ_OFF_CTRL0 && !wdata[4];
    endsequence
    a_mux_one_hot: assert property ($onehot0({analog_input_3,
        analog_input_2, analog_input_1, analog_input_0}))
        else $error("more than one analog input selected");
    a_mux_sel_ch1: assert property (s_ch1_on |-> ##[1:3] analog_input_1)
        else $error("pattern 101 did not select input 1");
    a_mux_grp_gate: assert property (s_grp_off |-> ##[1:3]
        !(analog_input_0 | analog_input_1 | analog_input_2 | analog_input_3))
        else $error("input selected without group enable");
    a_start_begins: assert property (s_go |-> ##[1:3] conv_busy)
        else $error("start write did not begin conversion");
    a_stop_aborts: assert property (s_halt |-> ##[1:3] !conv_busy)
        else $error("stop write did not end conversion");
    a_busy_min_len: assert property ($rose(conv_busy) |-> conv_busy[*8])
        else $error("conversion ended far too early");
    a_irq_cause: assert property ($rose(irq) |-> $past(conv_busy, 2)
        || $past(wr_stb, 1) || $past(wr_stb, 2))
        else $error("interrupt rose without completion or write");
    a_ladder_on: assert property (wr_stb && addr == `SARSEQ_OFF_CTRL1
        && wdata[5] |-> ##[1:2] ladder_connect)
        else $error("reference not connected");
    a_ladder_off: assert property (wr_stb && addr == `SARSEQ_OFF_CTRL1
        && !wdata[5] |-> ##[1:2] !ladder_connect)
        else $error("reference not disconnected");
endmodule : sarseq_sva

bind sarseq_top sarseq_sva #(.DATA_W(DATA_W)) u_sva (.ref_clk(ref_clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .osc_fast_tick(osc_fast_tick),
    .sar_code(sar_code), .sar_over_ref(sar_over_ref),
    .analog_input_0(analog_input_0), .analog_input_1(analog_input_1),
    .analog_input_2(analog_input_2), .analog_input_3(analog_input_3),
    .ladder_connect(ladder_connect), .sample_hold_on(sample_hold_on),
    .conv_busy(conv_busy), .irq(irq));

// ---- tb_top.sv ----
`timescale 1ns/1ns
`include "sarseq_defines.svh"
module tb_top;
    logic       ref_clk, rst_n, wr_stb, rd_stb, osc_fast_tick, sar_over_ref;
    logic [7:0] addr, wdata, rdata, rv;  // Bus and last read value
    logic [9:0] sar_code;                // Raw converter code
    logic       ai0, ai1, ai2, ai3, ladder_connect, sample_hold_on;
    logic       conv_busy, irq;
    logic [1:0] osc_div;                 // Oscillator tick divider
    int         miscompares, checks, cyc, busy_n, sh_n;

    sarseq_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .osc_fast_tick(osc_fast_tick), .sar_code(sar_code),
        .sar_over_ref(sar_over_ref), .analog_input_0(ai0),
        .analog_input_1(ai1), .analog_input_2(ai2), .analog_input_3(ai3),
        .ladder_connect(ladder_connect), .sample_hold_on(sample_hold_on),
        .conv_busy(conv_busy), .irq(irq));

    // Clock, 4 ns period
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Oscillator tick every third cycle, activity counters, timeout
    always @(posedge ref_clk) begin
        cyc++;
        osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
        osc_fast_tick <= (osc_div == 2'h2);
        busy_n += (conv_busy === 1'b1);
        sh_n += (sample_hold_on === 1'b1);
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    // Compare and count
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One-cycle register write
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask : wr
    // One-cycle read, data taken in the following cycle
    task automatic rd(logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        rv = rdata;
    endtask : rd
    // Reset values and an unmapped place
    task automatic t_regs();
        rd(`SARSEQ_OFF_CTRL0);
        chk("ctrl0_rst", rv, 8'h00);
        rd(`SARSEQ_OFF_CTRL1);
        chk("ctrl1_rst", rv, 8'h00);
        chk("ladder_rst", ladder_connect, 1'h0);
        wr(8'h10, 8'hFF);
        rd(8'h10);
        chk("unmapped", rv, 8'h00);
        $display("regs done");
    endtask : t_regs
    // Channel patterns 100..111, then group disabled
    task automatic t_mux();
        wr(`SARSEQ_OFF_CTRL0, 8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(`SARSEQ_OFF_CTRL0, 8'h34 + i[7:0]);
            repeat (3) @(posedge ref_clk);
            chk("mux", {ai3, ai2, ai1, ai0}, 4'h1 << i);
            rd(`SARSEQ_OFF_CTRL0);
            chk("ctrl0_rb", rv, 8'h14 + i[7:0]);
        end
        wr(`SARSEQ_OFF_CTRL0, 8'h07);
        repeat (3) @(posedge ref_clk);
        chk("mux_off", {ai3, ai2, ai1, ai0}, 4'h0);
        $display("mux done");
    endtask : t_mux
    // One-shot conversion with given settings and expected length
    task automatic t_shot(logic [7:0] c0, c1, c2, m, logic [9:0] code,
                          logic ovr, int exp, logic [7:0] lo, hi);
        int b0, s0, n;
        sar_code <= code;
        sar_over_ref <= ovr;
        wr(`SARSEQ_OFF_IRQ_MASK, m);
        wr(`SARSEQ_OFF_CTRL2, c2);
        wr(`SARSEQ_OFF_CTRL1, c1);
        repeat (260) @(posedge ref_clk);
        b0 = busy_n;
        s0 = sh_n;
        wr(`SARSEQ_OFF_CTRL0, c0);
        rd(`SARSEQ_OFF_CTRL0);
        chk("flag_busy", rv, c0);
        for (int k = 0; k < 1000 && conv_busy !== 1'b0; k++)
            @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        n = busy_n - b0;
        chk("length", (n >= exp - 6) && (n <= exp + 6), 1'h1);
        chk("hold_used", sh_n != s0, c2[0]);
        chk("irq_masked", irq, m[0]);
        rd(`SARSEQ_OFF_CTRL0);
        chk("flag_clr", rv, c0 & 8'hBF);
        rd(`SARSEQ_OFF_RES_LO);
        chk("res_lo", rv, lo);
        rd(`SARSEQ_OFF_RES_HI);
        chk("res_hi", rv, hi);
        rd(`SARSEQ_OFF_IRQ_STAT);
        chk("status", rv, 8'h01);
        wr(`SARSEQ_OFF_IRQ_MASK, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq_on", irq, 1'h1);
        wr(`SARSEQ_OFF_IRQ_STAT, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq_clr", irq, 1'h0);
        $display("one-shot done, %0d busy cycles", n);
    endtask : t_shot
    // Repeat mode runs on, updates result, no interrupt, stops on demand
    task automatic t_repeat();
        sar_code <= 10'h2A5;
        sar_over_ref <= 1'b0;
        wr(`SARSEQ_OFF_CTRL2, 8'h00);
        wr(`SARSEQ_OFF_CTRL1, 8'h30);
        wr(`SARSEQ_OFF_CTRL0, 8'h5C);
        repeat (150) @(posedge ref_clk);
        sar_code <= 10'h3FC;
        repeat (120) @(posedge ref_clk);
        chk("rep_busy", conv_busy, 1'h1);
        chk("rep_irq", irq, 1'h0);
        rd(`SARSEQ_OFF_RES_LO);
        chk("rep_res", rv, 8'hFF);
        rd(`SARSEQ_OFF_IRQ_STAT);
        chk("rep_stat", rv, 8'h00);
        wr(`SARSEQ_OFF_CTRL0, 8'h1C);
        repeat (4) @(posedge ref_clk);
        chk("rep_stop", conv_busy, 1'h0);
        // Stop write landed mid-conversion, so the result is marked spoiled
        rd(`SARSEQ_OFF_RES_HI);
        chk("rep_spoil", rv, 8'h80);
        rd(`SARSEQ_OFF_IRQ_STAT);
        chk("rep_spstat", rv, 8'h02);
        $display("repeat done");
    endtask : t_repeat
    // Verdict
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        {rst_n, wr_stb, rd_stb, addr, wdata, sar_over_ref} = '0;
        {osc_fast_tick, osc_div, sar_code} = '0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_mux();
        // Div4 8-bit, div2 10-bit, div1 8-bit hold, oscillator 10-bit hold
        t_shot(8'h54, 8'h20, 8'h00, 8'h00, 10'h2A5, 0, 196, 8'hA9, 8'h00);
        t_shot(8'hD4, 8'h28, 8'h00, 8'h01, 10'h2A5, 0, 118, 8'hA5, 8'h02);
        t_shot(8'h54, 8'h30, 8'h01, 8'h01, 10'h2A5, 0, 28, 8'hA9, 8'h00);
        t_shot(8'hD4, 8'h38, 8'h01, 8'h01, 10'h123, 1, 99, 8'hFF, 8'h03);
        t_repeat();
        finish_test();
    end
endmodule : tb_top
